// ==== hw/flash_program_erase_sequencer.sv ====
`timescale 1ns/1ps
// Behaviour
// RULE_01 - After preprogram, erase once, then enter the erase verify loop.
// RULE_02 - Erase verify walks upward from zero expecting all ones, stops on miss or end.
// RULE_03 - Resume erase verify from the last verified address after another erase.
// RULE_04 - Program verify is written after the program pulse duration; it ends programming.
// RULE_05 - After write recovery, read the byte and compare with expected data.
// RULE_06 - Write the read command to return the device to normal reads.
// RULE_07 - Program verify only directly after a byte program operation.
// RULE_08 - Erase verify only directly after a chip erase operation.
// RULE_09 - Optionally read back and compare once the read command is written.
// RULE_10 - The device powers up in read mode without supply sequencing.
// RULE_11 - Writes happen only with write strobe and chip select both low.
// RULE_12 - The device alters the array only after a set-up and execute pair.
// RULE_13 - Chip select from address decode, output enable from system read strobe.
// RULE_14 - Program set-up code, then a write carrying address and data.
// RULE_15 - Erase code written twice starts chip erasure.
// RULE_16 - Erase verify is written with its address before each byte checked.
// RULE_17 - Program at most a bounded number of pulses per byte, each verified.
// RULE_18 - On pulse exhaustion stop, return to read mode and report failure.
module flash_program_erase_sequencer #(
   parameter int ADDR_W = 17,
   parameter int MAX_PULSES = flash_seq_pkg::MAX_PROG_PULSES,
   parameter int MAX_ERASES = flash_seq_pkg::MAX_ERASE_PULSES,
   parameter int PROG_CYC = flash_seq_pkg::PROG_PULSE_CYC,
   parameter int ERASE_CYC = flash_seq_pkg::ERASE_PULSE_CYC,
   parameter int RECOV_CYC = flash_seq_pkg::RECOVERY_CYC,
   parameter logic [16:0] LAST_ADDR = 17'h1FFFF,
   parameter bit FINAL_CHECK = 1'b1
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire flash_seq_pkg::host_req_t req_in,
   output logic rsp_valid_out,
   output flash_seq_pkg::host_rsp_t rsp_out,
   output flash_seq_pkg::mem_bus_t bus_out,
   input wire logic [7:0] dq_in
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   typedef enum logic [4:0] {
      S_IDLE,
      S_P_SETUP,
      S_P_DATA,
      S_P_WAIT,
      S_P_VERIFY,
      S_P_RECOV,
      S_P_READ,
      S_PRE_NEXT,
      S_E_SETUP,
      S_E_GO,
      S_E_WAIT,
      S_EV_CMD,
      S_EV_RECOV,
      S_EV_READ,
      S_RD_CMD,
      S_FINAL_READ,
      S_DONE
   } state_t;

   typedef enum logic [1:0] {
      J_PROG,
      J_PREPROG,
      J_ERASE,
      J_READ
   } job_t;

   state_t state;
   job_t job;
   logic [16:0] addr;
   logic [16:0] ev_addr;
   logic [7:0] expect_data;
   logic [7:0] pulses;
   logic [15:0] erases;
   logic [31:0] timer;
   logic failed;
   logic [2:0] phase;
   logic [7:0] cap;

   // Bus cycle engine: one write or read, a fixed short sequence of phases.
   logic cyc_start;
   logic cyc_is_write;
   logic [7:0] cyc_data;
   logic [16:0] cyc_addr;
   logic [7:0] cyc_cnt;
   logic cyc_busy;
   logic cyc_done;

   wire cmp_ok = (cap == expect_data);
   wire timer_zero = (timer == 32'h0000_0000);
   wire at_end = (addr == LAST_ADDR);
   wire prog_exhausted = (pulses >= 8'(MAX_PULSES));
   wire erase_exhausted = (erases >= 16'(MAX_ERASES));

   assign req_ready_out = (state == S_IDLE);

   // ----------------------------------------
   // Bus cycle engine
   // ----------------------------------------
   // Write strobe and chip select fall and rise together so a write is qualified
   // only during the low window; both idle high, which blocks stray writes. RULE_11
   wire [7:0] cyc_low_len = cyc_is_write ? 8'(flash_seq_pkg::WE_LOW_CYC)
                                          : 8'(flash_seq_pkg::READ_CYC);
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cyc_busy <= 1'b0;
         cyc_cnt <= 8'h00;
         cyc_done <= 1'b0;
         bus_out <= '{addr: 17'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                      dq: 8'h00, dq_oe: 1'b0};
         cap <= 8'h00;
      end else begin
         cyc_done <= 1'b0;
         if (cyc_start && !cyc_busy) begin
            cyc_busy <= 1'b1;
            cyc_cnt <= 8'h00;
            bus_out.addr <= cyc_addr;
            bus_out.dq <= cyc_data;
            bus_out.dq_oe <= cyc_is_write;
            bus_out.ce_n <= 1'b0;
            bus_out.we_n <= !cyc_is_write;
            bus_out.oe_n <= cyc_is_write; // RULE_13
         end else if (cyc_busy) begin
            cyc_cnt <= cyc_cnt + 8'h01;
            if (cyc_cnt == cyc_low_len) begin
               if (!cyc_is_write) begin
                  cap <= dq_in;
               end
               bus_out.ce_n <= 1'b1;
               bus_out.we_n <= 1'b1;
               bus_out.oe_n <= 1'b1;
            end
            if (cyc_cnt == cyc_low_len + 8'(flash_seq_pkg::WE_HIGH_CYC)) begin
               bus_out.dq_oe <= 1'b0;
               cyc_busy <= 1'b0;
               cyc_done <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Cycle requests per state
   // ----------------------------------------
   always_comb begin
      cyc_is_write = 1'b1;
      cyc_data = flash_seq_pkg::CMD_READ;
      cyc_addr = addr;
      unique case (state)
         S_P_SETUP: cyc_data = flash_seq_pkg::CMD_PROG_SETUP; // RULE_14
         S_P_DATA: cyc_data = expect_data; // RULE_14
         S_P_VERIFY: cyc_data = flash_seq_pkg::CMD_PROG_VERIFY; // RULE_07
         S_E_SETUP: cyc_data = flash_seq_pkg::CMD_ERASE; // RULE_15
         S_E_GO: cyc_data = flash_seq_pkg::CMD_ERASE; // RULE_15
         S_EV_CMD: cyc_data = flash_seq_pkg::CMD_ERASE_VERIFY; // RULE_16
         S_RD_CMD: cyc_data = flash_seq_pkg::CMD_READ; // RULE_06
         S_P_READ, S_EV_READ, S_FINAL_READ: cyc_is_write = 1'b0; // RULE_05
         default: cyc_data = flash_seq_pkg::CMD_READ;
      endcase
   end

   assign cyc_start = (phase == 3'd0) && (state inside {S_P_SETUP, S_P_DATA, S_P_VERIFY,
      S_P_READ, S_E_SETUP, S_E_GO, S_EV_CMD, S_EV_READ, S_RD_CMD, S_FINAL_READ});

   // ----------------------------------------
   // Algorithm sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= S_IDLE;
         job <= J_PROG;
         addr <= 17'h00000;
         ev_addr <= 17'h00000;
         expect_data <= 8'h00;
         pulses <= 8'h00;
         erases <= 16'h0000;
         timer <= 32'h0000_0000;
         failed <= 1'b0;
         phase <= 3'd0;
         rsp_valid_out <= 1'b0;
         rsp_out <= '0;
      end else begin
         rsp_valid_out <= 1'b0;
         if (cyc_start) begin
            phase <= 3'd1;
         end
         if (!timer_zero) begin
            timer <= timer - 32'h0000_0001;
         end
         unique case (state)
            S_IDLE: begin
               failed <= 1'b0;
               pulses <= 8'h00;
               erases <= 16'h0000;
               if (req_valid_in) begin
                  addr <= req_in.addr;
                  expect_data <= req_in.data;
                  unique case (req_in.op)
                     flash_seq_pkg::OP_PROGRAM: begin
                        job <= J_PROG;
                        state <= S_P_SETUP;
                     end
                     flash_seq_pkg::OP_ERASE: begin
                        job <= J_PREPROG;
                        addr <= 17'h00000;
                        ev_addr <= 17'h00000;
                        expect_data <= flash_seq_pkg::DATA_PREPROG;
                        state <= S_P_SETUP;
                     end
                     default: begin
                        job <= J_READ;
                        state <= S_RD_CMD;
                     end
                  endcase
               end
            end
            S_P_SETUP, S_E_SETUP, S_EV_CMD: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  state <= state.next();
               end
            end
            S_P_DATA: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  pulses <= pulses + 8'h01; // RULE_17
                  timer <= 32'(PROG_CYC);
                  state <= S_P_WAIT;
               end
            end
            S_P_WAIT: begin
               if (timer_zero) begin
                  state <= S_P_VERIFY; // RULE_04
               end
            end
            S_P_VERIFY: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  timer <= 32'(RECOV_CYC);
                  state <= S_P_RECOV;
               end
            end
            S_P_RECOV: begin
               if (timer_zero) begin
                  state <= S_P_READ; // RULE_05
               end
            end
            S_P_READ: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  if (cmp_ok) begin
                     pulses <= 8'h00;
                     state <= (job == J_PREPROG) ? S_PRE_NEXT : S_RD_CMD;
                  end else if (prog_exhausted) begin
                     failed <= 1'b1; // RULE_18
                     state <= S_RD_CMD;
                  end else begin
                     state <= S_P_SETUP; // RULE_17
                  end
               end
            end
            S_PRE_NEXT: begin
               if (at_end) begin
                  addr <= ev_addr;
                  expect_data <= flash_seq_pkg::DATA_ERASED;
                  job <= J_ERASE;
                  state <= S_E_SETUP; // RULE_01
               end else begin
                  addr <= addr + 17'h00001;
                  state <= S_P_SETUP;
               end
            end
            S_E_GO: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  erases <= erases + 16'h0001;
                  timer <= 32'(ERASE_CYC);
                  state <= S_E_WAIT;
               end
            end
            S_E_WAIT: begin
               if (timer_zero) begin
                  state <= S_EV_CMD; // RULE_08
               end
            end
            S_EV_RECOV: begin
               if (timer_zero) begin
                  state <= S_EV_READ;
               end
            end
            S_EV_READ: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  if (!cmp_ok) begin
                     // Resuming here skips bytes already proven erased. RULE_03
                     ev_addr <= addr;
                     if (erase_exhausted) begin
                        failed <= 1'b1;
                        state <= S_RD_CMD;
                     end else begin
                        state <= S_E_SETUP;
                     end
                  end else if (at_end) begin
                     state <= S_RD_CMD; // RULE_02
                  end else begin
                     addr <= addr + 17'h00001; // RULE_02
                     state <= S_EV_CMD;
                  end
               end
            end
            S_RD_CMD: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  state <= (FINAL_CHECK || job == J_READ) ? S_FINAL_READ : S_DONE; // RULE_09
               end
            end
            S_FINAL_READ: begin
               if (cyc_done) begin
                  phase <= 3'd0;
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               rsp_valid_out <= 1'b1;
               rsp_out.rdata <= cap;
               rsp_out.fail_addr <= addr;
               rsp_out.prog_fail <= failed && (job != J_ERASE); // RULE_18
               rsp_out.erase_fail <= failed && (job == J_ERASE);
               rsp_out.ok <= !failed && (job == J_READ || job == J_ERASE
                  || !FINAL_CHECK || cap == expect_data);
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
         if (state == S_EV_CMD && cyc_done) begin
            timer <= 32'(RECOV_CYC);
         end
      end
   end

endmodule

// ==== inc/flash_seq_pkg.sv ====
package flash_seq_pkg;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
   localparam logic [7:0] DATA_ERASED = 8'hFF;
   localparam logic [7:0] DATA_PREPROG = 8'h00;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PROGRAM_PULSE_DURATION_NS = 10000;
   localparam int ERASE_PULSE_DURATION_NS = 9500000;
   localparam int WRITE_RECOVERY_NS = 6000;
   localparam int WRITE_PULSE_NS = 80;
   localparam int WRITE_HIGH_NS = 20;
   localparam int READ_ACCESS_NS = 150;
   localparam int PROG_PULSE_CYC = (PROGRAM_PULSE_DURATION_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   // The erase pulse in picoseconds overflows a 32-bit int, so it is scaled in nanoseconds.
   localparam int ERASE_PULSE_CYC = (ERASE_PULSE_DURATION_NS + CLK_PERIOD_PS / 1000 - 1)
      / (CLK_PERIOD_PS / 1000);
   localparam int RECOVERY_CYC = (WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WE_LOW_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WE_HIGH_CYC = (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MAX_PROG_PULSES = 25;
   localparam int MAX_ERASE_PULSES = 1000;

   // ----------------------------------------
   // Host command port
   // ----------------------------------------
   typedef enum logic [1:0] {
      OP_PROGRAM,
      OP_ERASE,
      OP_READ
   } host_op_t;

   typedef struct packed {
      host_op_t op;
      logic [16:0] addr;
      logic [7:0] data;
   } host_req_t;

   typedef struct packed {
      logic ok;
      logic prog_fail;
      logic erase_fail;
      logic [16:0] fail_addr;
      logic [7:0] rdata;
   } host_rsp_t;

   // Memory bus toward the device; data lines are two-way.
   typedef struct packed {
      logic [16:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [7:0] dq;
      logic dq_oe;
   } mem_bus_t;

endpackage

// ==== sim/flash_device_model.sv ====
`timescale 1ns/1ps
module flash_device_model (
   input wire logic clk_in,
   input wire flash_seq_pkg::mem_bus_t bus_in,
   output logic [7:0] dq_out
);
   typedef enum logic [2:0] {M_READ, M_PSET, M_PROG, M_PVER, M_ESET, M_ERASE, M_EVER} mode_t;
   mode_t mode = M_READ;
   logic [7:0] mem [4] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C};
   logic [1:0] pa = 2'h0;
   logic [7:0] pd = 8'h00;
   logic [1:0] ea = 2'h0;
   logic [7:0] last = 8'h00;
   logic prev_we = 1'b1;
   logic prev_ce = 1'b1;
   int prog_need = 1;
   int erase_need = 1;
   bit slow_erase = 1'b0;
   int pcnt = 0;
   int ecnt = 0;
   int vcnt = 0;
   wire [1:0] ra = (mode == M_PVER) ? pa : (mode == M_EVER) ? ea : bus_in.addr[1:0];
   wire drive = !bus_in.ce_n && !bus_in.oe_n;
   // A released bus shows the inverse of its last value, so stale data never passes.
   assign dq_out = drive ? mem[ra] : ~last;
   task automatic take_write(input logic [7:0] d, input logic [1:0] a);
      if (mode == M_PSET) begin
         pa = a;
         pd = d;
         mode = M_PROG;
         return;
      end
      if (mode == M_PROG && d == flash_seq_pkg::CMD_PROG_VERIFY) begin
         pcnt++;
         if (pcnt >= prog_need)
            mem[pa] = mem[pa] & pd;
      end
      if (mode == M_ERASE && d == flash_seq_pkg::CMD_ERASE_VERIFY) begin
         ecnt++;
         foreach (mem[i])
            if (ecnt >= erase_need + (slow_erase ? i : 0))
               mem[i] = 8'hFF;
      end
      ea = a;
      case (d)
         flash_seq_pkg::CMD_PROG_SETUP: mode = M_PSET;
         flash_seq_pkg::CMD_ERASE: mode = (mode == M_ESET) ? M_ERASE : M_ESET;
         flash_seq_pkg::CMD_PROG_VERIFY: mode = (mode == M_PROG) ? M_PVER : M_READ;
         flash_seq_pkg::CMD_ERASE_VERIFY: mode = (mode inside {M_ERASE, M_EVER}) ? M_EVER : M_READ;
         default: mode = M_READ;
      endcase
      if (mode == M_EVER)
         vcnt++;
   endtask
   always @(posedge clk_in) begin
      if (drive)
         last <= mem[ra];
      prev_we <= bus_in.we_n;
      prev_ce <= bus_in.ce_n;
      if (!prev_we && bus_in.we_n && !prev_ce)
         take_write(bus_in.dq, bus_in.addr[1:0]);
   end
endmodule

// ==== sim/flash_program_erase_sequencer_bench.sv ====
`timescale 1ns/1ps
module flash_program_erase_sequencer_bench;
   localparam int NBYTES = 4;
   localparam int NERASE = 6;
   localparam int MAXP = flash_seq_pkg::MAX_PROG_PULSES;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic req_ready_out;
   flash_seq_pkg::host_req_t req_in = '0;
   logic rsp_valid_out;
   flash_seq_pkg::host_rsp_t rsp_out;
   flash_seq_pkg::host_rsp_t rsp;
   flash_seq_pkg::mem_bus_t bus_out;
   logic [7:0] dq_in;
   logic [7:0] shadow [4];
   int n_errors = 0;
   int comparisons = 0;
   int seed = 57;
   flash_program_erase_sequencer #(.MAX_ERASES(NERASE), .PROG_CYC(20), .ERASE_CYC(50),
      .RECOV_CYC(10), .LAST_ADDR(17'h00003)) i_dut (.sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
      .req_in(req_in), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
      .bus_out(bus_out), .dq_in(dq_in));
   flash_device_model i_dev (.clk_in(sys_clk_in), .bus_in(bus_out), .dq_out(dq_in));
   initial begin
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic int restart_verifies(input int n);
      int s = n;
      for (int k = 1; k < n; k++)
         s += k + 1;
      return s;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // A job is counted as hung after a bound far above the slowest legal job.
   task automatic run_job(input flash_seq_pkg::host_op_t op, input logic [1:0] a,
         input logic [7:0] d);
      int k;
      i_dev.pcnt = 0;
      i_dev.ecnt = 0;
      i_dev.vcnt = 0;
      req_in = '{op: op, addr: {15'h0000, a}, data: d};
      req_valid_in = 1'b1;
      @(negedge sys_clk_in);
      req_valid_in = 1'b0;
      for (k = 0; k < 20000; k++) begin
         @(negedge sys_clk_in);
         if (rsp_valid_out === 1'b1)
            break;
      end
      if (k == 20000) begin
         n_errors++;
         complete_run();
      end
      rsp = rsp_out;
      @(negedge sys_clk_in);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [1:0] a;
      logic [7:0] d;
      int need;
      logic fail;
      repeat (4) @(negedge sys_clk_in);
      check(32'({bus_out.ce_n, bus_out.oe_n, bus_out.we_n, bus_out.dq_oe, req_ready_out}),
         32'h0000001D);
      rstn_in = 1'b1;
      @(negedge sys_clk_in);
      $display("Test reset state done");
      i_dev.slow_erase = 1'b1;
      run_job(flash_seq_pkg::OP_ERASE, 2'h0, 8'h00);
      check(32'(rsp.ok), 32'h00000001);
      check(i_dev.pcnt, NBYTES);
      check(i_dev.ecnt, NBYTES);
      check(32'(i_dev.vcnt < restart_verifies(NBYTES)), 32'h00000001);
      foreach (shadow[i]) begin
         shadow[i] = 8'hFF;
         check(32'(i_dev.mem[i]), 32'h000000FF);
      end
      $display("Test slow erase done");
      for (int i = 0; i < 7; i++) begin
         a = 2'($random(seed));
         d = 8'($random(seed));
         need = (i == 6) ? 100 : 1 + int'($unsigned($random(seed)) % 4);
         i_dev.prog_need = need;
         fail = (need > MAXP) || ((shadow[a] & d) !== d);
         run_job(flash_seq_pkg::OP_PROGRAM, a, d);
         check(32'(rsp.ok), 32'(!fail));
         check(32'(rsp.prog_fail), 32'(fail));
         check(i_dev.pcnt, fail ? MAXP : need);
         if (fail)
            check(32'(rsp.fail_addr), 32'(a));
         if (need <= MAXP)
            shadow[a] = shadow[a] & d;
         run_job(flash_seq_pkg::OP_READ, a, 8'h00);
         check(32'(rsp.rdata), 32'(shadow[a]));
      end
      $display("Test program and read done");
      i_dev.slow_erase = 1'b0;
      i_dev.prog_need = 1;
      i_dev.erase_need = 1000;
      run_job(flash_seq_pkg::OP_ERASE, 2'h0, 8'h00);
      check(32'(rsp.erase_fail), 32'h00000001);
      check(i_dev.ecnt, NERASE);
      check(i_dev.vcnt, NERASE);
      run_job(flash_seq_pkg::OP_READ, 2'h3, 8'h00);
      check(32'(rsp.rdata), 32'h00000000);
      $display("Test erase limit done");
      complete_run();
   end
endmodule
bind flash_program_erase_sequencer flash_seq_asserts #(.PROG_CYC(PROG_CYC),
   .RECOV_CYC(RECOV_CYC)) u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
   .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_in(req_in),
   .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .bus_out(bus_out), .dq_in(dq_in));

// ==== sim/flash_seq_asserts.sv ====
`timescale 1ns/1ps
module flash_seq_asserts #(
   parameter int PROG_CYC = 20,
   parameter int RECOV_CYC = 10
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire flash_seq_pkg::host_req_t req_in,
   input wire logic rsp_valid_out,
   input wire flash_seq_pkg::host_rsp_t rsp_out,
   input wire flash_seq_pkg::mem_bus_t bus_out,
   input wire logic [7:0] dq_in
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // ----------------------------------------
   // Write history
   // ----------------------------------------
   logic prev_we;
   logic [15:0] low_cnt;
   logic [15:0] gap;
   logic [7:0] w1;
   logic [7:0] w2;
   wire wr_end = !prev_we && bus_out.we_n;
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prev_we <= 1'b1;
         low_cnt <= 16'h0000;
         gap <= 16'h0000;
         w1 <= 8'h00;
         w2 <= 8'h00;
      end else begin
         prev_we <= bus_out.we_n;
         low_cnt <= bus_out.we_n ? 16'h0000 : low_cnt + 16'h0001;
         gap <= (!bus_out.we_n) ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
         if (wr_end) begin
            w1 <= bus_out.dq;
            w2 <= w1;
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_we_ce;
      !bus_out.we_n |-> !bus_out.ce_n && bus_out.oe_n;
   endproperty
   a_we_ce: assert property (p_we_ce) else $error("write strobe without select");
   property p_we_width;
      wr_end |-> low_cnt >= 16'(flash_seq_pkg::WE_LOW_CYC) && bus_out.dq_oe;
   endproperty
   a_we_width: assert property (p_we_width) else $error("short write pulse");
   property p_oe_release;
      !bus_out.oe_n |-> !bus_out.dq_oe;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("data driven during read");
   property p_prog_wait;
      $fell(bus_out.we_n) && bus_out.dq == 8'hC0 && w1 != 8'h40 |-> gap >= PROG_CYC;
   endproperty
   a_prog_wait: assert property (p_prog_wait) else $error("verify before pulse end");
   property p_verify_order;
      wr_end && bus_out.dq == 8'hC0 && w1 != 8'h40 |-> w2 == 8'h40;
   endproperty
   a_verify_order: assert property (p_verify_order) else $error("stray program verify");
   property p_erase_order;
      wr_end && bus_out.dq == 8'hA0 && w1 != 8'h40 |-> w1 == 8'h20 || w1 == 8'hA0;
   endproperty
   a_erase_order: assert property (p_erase_order) else $error("stray erase verify");
   property p_recovery;
      $fell(bus_out.oe_n) && (w1 == 8'hC0 || w1 == 8'hA0) |-> gap >= RECOV_CYC;
   endproperty
   a_recovery: assert property (p_recovery) else $error("read before recovery");
   property p_read_mode;
      rsp_valid_out && !rsp_out.erase_fail |-> w1 == 8'h00;
   endproperty
   a_read_mode: assert property (p_read_mode) else $error("job ended off read mode");
   property p_rsp_pulse;
      rsp_valid_out |=> !rsp_valid_out && req_ready_out && bus_out.ce_n;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer not a single pulse");
endmodule
